// ===== host_clock_output_control.v
// Host clock output controller: drives the divided reference clock out
// to the host and decides, per operating mode, whether it runs.
// Assumes the clock input is the crystal reference, that the serial
// control bus decoder presents a parallel register port on this clock,
// and that mode changes and packet events come from logic on this clock.
`timescale 1ns/100ps
`include "host_clock_map.vh"

// Notes on behaviour
// - Host clock divided from the reference crystal
// - Software selects 12, 6, 3 MHz or off
// - Runs in receive and transmit unless off
// - In idle, restarts after a packet arrives
// - Housekeeping restarts it only if wake enabled
// - Reset enters the mode chosen in options
// - On idle entry, runs programmed cycles then stops
module host_clock_output_control (
   input wire clock,
   input wire resetn,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire modeReqValid,
   input wire [2:0] modeReq,
   input wire packetReceived,
   output reg [7:0] regRdata_r,
   output reg [2:0] mode_r,
   output reg hostClockPin_r
);

   // ************************************************************
   // Register file
   // ************************************************************

   reg [7:0] genOptA_r;
   reg [7:0] genOptB_r;
   reg [7:0] idleCfg_r;
   reg [7:0] housekeepCfg_r;

   // Mode code held in the power-on field of the options reset value
   localparam [7:0] GOA_RST = `GOA_RESET;
   localparam [2:0] POR_MODE = {1'b0, GOA_RST[`GOA_POR_MSB:`GOA_POR_LSB]};

   // Software writes; only the documented offsets are stored
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         genOptA_r <= `GOA_RESET;
         genOptB_r <= `GOB_RESET;
         idleCfg_r <= `IDLE_CFG_RESET;
         housekeepCfg_r <= `HK_CFG_RESET;
      end else if (regWrite) begin
         case (regAddr)
            `OFS_GEN_OPT_A: begin
               genOptA_r <= regWdata;
            end
            `OFS_GEN_OPT_B: begin
               genOptB_r <= regWdata;
            end
            `OFS_IDLE_CFG: begin
               idleCfg_r <= regWdata;
            end
            `OFS_HOUSEKEEP_CFG: begin
               housekeepCfg_r <= regWdata;
            end
            default: begin
               genOptA_r <= genOptA_r;
            end
         endcase
      end
   end

   // ************************************************************
   // Divider
   // ************************************************************

   wire [1:0] freqSel;
   wire divLevel;
   wire fallTick;

   assign freqSel = genOptB_r[`GOB_FSEL_MSB:`GOB_FSEL_LSB];

   ref_clock_divider divider (
      .clock(clock),
      .resetn(resetn),
      .freqSel(freqSel),
      .divLevel_r(divLevel),
      .fallTick_r(fallTick)
   );

   // ************************************************************
   // Operating mode
   // ************************************************************

   // Reset takes the constant power-on mode; later requests replace it
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode_r <= POR_MODE;
      end else if (modeReqValid) begin
         mode_r <= modeReq;
      end
   end

   // ************************************************************
   // Idle hold count and restart flags
   // ************************************************************

   reg [7:0] idleCount_r;
   reg idleRestart_r;
   reg [2:0] prevMode_r;
   wire idleEntry;

   assign idleEntry = (mode_r == `MODE_IDLE) && (prevMode_r != `MODE_IDLE);

   // Previous mode, to spot the entry into idle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prevMode_r <= `MODE_STANDBY;
      end else begin
         prevMode_r <= mode_r;
      end
   end

   // Counts host clock periods after idle entry; one period per falling edge
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idleCount_r <= 8'h00;
      end else if (idleEntry) begin
         idleCount_r <= idleCfg_r;
      end else if (mode_r != `MODE_IDLE) begin
         idleCount_r <= 8'h00;
      end else if (fallTick && (idleCount_r != 8'h00)) begin
         idleCount_r <= idleCount_r - 8'h01;
      end
   end

   // A packet in idle restarts the clock until idle is left; set wins
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idleRestart_r <= 1'b0;
      end else if ((mode_r == `MODE_IDLE) && packetReceived) begin
         idleRestart_r <= 1'b1;
      end else if ((mode_r != `MODE_IDLE) || idleEntry) begin
         idleRestart_r <= 1'b0;
      end
   end

   // ************************************************************
   // Run decision and glitch-free gating
   // ************************************************************

   reg runNxt;
   reg run_r;

   // Per-mode permission to drive the pin
   always @*  begin
      case (mode_r)
         `MODE_RX, `MODE_TX: begin
            runNxt = 1'b1;
         end
         `MODE_IDLE: begin
            runNxt = (idleCount_r != 8'h00) || idleRestart_r;
         end
         `MODE_HOUSEKEEP: begin
            runNxt = housekeepCfg_r[`HK_WAKE_HOST];
         end
         `MODE_STANDBY: begin
            runNxt = genOptA_r[`GOA_STANDBY_OUT];
         end
         default: begin
            runNxt = 1'b0;
         end
      endcase
   end

   // The gate only moves while the divided level is low, so the host never
   // sees a shortened high pulse when the clock starts or stops
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_r <= 1'b0;
      end else if (!divLevel) begin
         run_r <= runNxt;
      end
   end

   // Pin level; an off rate leaves the divider level at zero
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hostClockPin_r <= 1'b0;
      end else begin
         hostClockPin_r <= divLevel & run_r;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************

   reg [7:0] readNxt;

   // Read mux; unmapped offsets read as zero
   always @* begin
      case (regAddr)
         `OFS_GEN_OPT_A: begin
            readNxt = genOptA_r;
         end
         `OFS_GEN_OPT_B: begin
            readNxt = genOptB_r;
         end
         `OFS_IDLE_CFG: begin
            readNxt = idleCfg_r;
         end
         `OFS_HOUSEKEEP_CFG: begin
            readNxt = housekeepCfg_r;
         end
         `OFS_CLK_STATUS: begin
            readNxt = {3'h0, idleRestart_r, run_r, mode_r};
         end
         default: begin
            readNxt = 8'h00;
         end
      endcase
   end

   // Read data held until the next read
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         regRdata_r <= 8'h00;
      end else if (regRead) begin
         regRdata_r <= readNxt;
      end
   end

endmodule

// ===== host_clock_map.vh
// Constants for the host clock output controller: register offsets,
// field positions, reset values and mode codes.
// Assumes it is included by bare name from each design file.
`ifndef HOST_CLOCK_MAP_VH
`define HOST_CLOCK_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_GEN_OPT_A 8'h0c
`define OFS_GEN_OPT_B 8'h0d
`define OFS_IDLE_CFG 8'h0e
`define OFS_HOUSEKEEP_CFG 8'h0f
`define OFS_CLK_STATUS 8'h10

// ************************************************************
// Field positions
// ************************************************************
`define GOA_STANDBY_OUT 0
`define GOA_POR_LSB 1
`define GOA_POR_MSB 2
`define GOB_FSEL_LSB 0
`define GOB_FSEL_MSB 1
`define HK_WAKE_HOST 6

// ************************************************************
// Reset values
// ************************************************************
`define GOA_RESET 8'h02
`define GOB_RESET 8'h03
`define IDLE_CFG_RESET 8'h10
`define HK_CFG_RESET 8'h00

// ************************************************************
// Frequency select codes (reference 24 MHz)
// ************************************************************
`define FSEL_OFF 2'h0
`define FSEL_12M 2'h1
`define FSEL_6M 2'h2
`define FSEL_3M 2'h3

// ************************************************************
// Operating modes
// ************************************************************
`define MODE_STANDBY 3'h0
`define MODE_IDLE 3'h1
`define MODE_RX 3'h2
`define MODE_TX 3'h3
`define MODE_HOUSEKEEP 3'h4

`endif

// ===== ref_clock_divider.v
// Divider that derives the host clock level from the reference clock.
// Assumes the module clock is the crystal reference; output is a level
// sampled by the parent, plus a one-cycle pulse on each falling edge.
`timescale 1ns/100ps
`include "host_clock_map.vh"

module ref_clock_divider (
   input wire clock,
   input wire resetn,
   input wire [1:0] freqSel,
   output reg divLevel_r,
   output reg fallTick_r
);

   reg [2:0] count_r;
   reg levelNxt;

   // Free running count; each bit is the reference halved once more
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_r <= 3'h0;
      end else begin
         count_r <= count_r + 3'h1;
      end
   end

   // Pick the tap for the selected rate
   always @* begin
      case (freqSel)
         `FSEL_12M: begin
            levelNxt = count_r[0];
         end
         `FSEL_6M: begin
            levelNxt = count_r[1];
         end
         `FSEL_3M: begin
            levelNxt = count_r[2];
         end
         default: begin
            levelNxt = 1'b0;
         end
      endcase
   end

   // Registered level and falling-edge marker
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         divLevel_r <= 1'b0;
         fallTick_r <= 1'b0;
      end else begin
         divLevel_r <= levelNxt;
         fallTick_r <= divLevel_r & ~levelNxt;
      end
   end

endmodule

// ===== host_model.sv
// Host controller model, clocked by the host clock pin.
// Assumes the bench pulses clearCount between measurements.
`timescale 1ns/100ps
module host_model (
   input wire hostClk,
   input wire clearCount,
   output reg [7:0] edgeCount
);
   // Count the host's rising clock edges; async clear, since the pin may be stopped
   always @(posedge hostClk or posedge clearCount) begin
      if (clearCount) begin
         edgeCount <= 8'h00;
      end else begin
         edgeCount <= edgeCount + 8'h01;
      end
   end
endmodule

// ===== host_clock_output_control_assertions.sv
// Port checker for the host clock output controller.
// Assumes it is bound to the controller and sees its ports only.
`timescale 1ns/100ps
module host_clock_output_control_assertions (
   input wire clock,
   input wire resetn,
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire modeReqValid,
   input wire [2:0] modeReq,
   input wire packetReceived,
   input wire [2:0] mode_r,
   input wire hostClockPin_r
);
   reg [1:0] fsel_r;
   reg sby_r;
   reg wake_r;
   reg [3:0] selAge_r;
   reg [2:0] highRun_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shadow the gating fields: the registers are not visible from here
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fsel_r <= 2'h3;
         sby_r <= 1'b0;
         wake_r <= 1'b0;
      end else if (regWrite) begin
         if (regAddr == 8'h0d) fsel_r <= regWdata[1:0];
         if (regAddr == 8'h0c) sby_r <= regWdata[0];
         if (regAddr == 8'h0f) wake_r <= regWdata[6];
      end
   end
   // Age of the rate select and length of the current high run on the pin;
   // a rate change may stretch one high phase, which the host tolerates
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         selAge_r <= 4'h0;
         highRun_r <= 3'h0;
      end else begin
         if (regWrite && regAddr == 8'h0d && regWdata[1:0] != fsel_r) begin
            selAge_r <= 4'h0;
         end else if (selAge_r != 4'hf) begin
            selAge_r <= selAge_r + 4'h1;
         end
         if (!hostClockPin_r) begin
            highRun_r <= 3'h0;
         end else if (highRun_r != 3'h7) begin
            highRun_r <= highRun_r + 3'h1;
         end
      end
   end
   AST_MODE_TAKE: assert property (modeReqValid |=> mode_r == $past(modeReq)) else $error("mode");
   AST_MODE_HOLD: assert property (!modeReqValid |=> $stable(mode_r)) else $error("mode hold");
   AST_DUTY: assert property (selAge_r == 4'hf |-> highRun_r < 3'h5) else $error("high too long");
   AST_RUN_RXTX: assert property ((mode_r[2:1] == 2'h1 && fsel_r != 2'h0) [*8] |-> ##[0:8] hostClockPin_r)
      else $error("no clock");
   AST_OFF: assert property ((fsel_r == 2'h0) [*8] |-> !hostClockPin_r) else $error("off");
   AST_STBY: assert property ((mode_r == 3'h0 && !sby_r) [*8] |-> !hostClockPin_r) else $error("stby");
   AST_HK: assert property ((mode_r == 3'h4 && !wake_r) [*8] |-> !hostClockPin_r) else $error("hk");
   AST_IDLE_PKT: assert property (packetReceived && mode_r == 3'h1 && fsel_r != 2'h0 && !modeReqValid
      ##1 (mode_r == 3'h1) [*8] |-> ##[0:8] hostClockPin_r) else $error("no restart");
endmodule
bind host_clock_output_control host_clock_output_control_assertions chk (.clock(clock), .resetn(resetn),
   .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .modeReqValid(modeReqValid), .modeReq(modeReq),
   .packetReceived(packetReceived), .mode_r(mode_r), .hostClockPin_r(hostClockPin_r));

// ===== host_clock_output_control_bench.sv
// Self-checking bench for the host clock output controller.
// Assumes the host model counts rising pin edges; inputs change at falling edges.
`timescale 1ns/100ps
module host_clock_output_control_bench;
   reg clock, resetn, regWrite, regRead, modeReqValid, packetReceived, clearCount;
   reg [7:0] regAddr, regWdata;
   reg [2:0] modeReq;
   wire [7:0] regRdata_r, edgeCount;
   wire [2:0] mode_r;
   wire hostClockPin_r;
   integer err_count, comparisons, f;
   host_clock_output_control uut (.clock(clock), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .modeReqValid(modeReqValid), .modeReq(modeReq),
      .packetReceived(packetReceived), .regRdata_r(regRdata_r), .mode_r(mode_r), .hostClockPin_r(hostClockPin_r));
   host_model host (.hostClk(hostClockPin_r), .clearCount(clearCount), .edgeCount(edgeCount));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Range compare; the xor test keeps unknowns from passing
   task check(input [7:0] got, input [7:0] lo, input [7:0] hi);
      begin
         comparisons = comparisons + 1;
         if ((got ^ got) !== 8'h00 || got < lo || got > hi) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clock);
         regAddr = a;
         regWdata = d;
         regWrite = 1'b1;
         @(negedge clock);
         regWrite = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(negedge clock);
         regAddr = a;
         regRead = 1'b1;
         @(negedge clock);
         regRead = 1'b0;
         check(regRdata_r, e, e);
      end
   endtask
   task setm(input [2:0] m);
      begin
         @(negedge clock);
         modeReq = m;
         modeReqValid = 1'b1;
         @(negedge clock);
         modeReqValid = 1'b0;
      end
   endtask
   // Settle s cycles, then count host edges over n cycles; edge phase gives +-1
   task measure(input integer s, input integer n, input [7:0] lo, input [7:0] hi);
      begin
         repeat (s) @(negedge clock);
         clearCount = 1'b1;
         @(negedge clock);
         clearCount = 1'b0;
         repeat (n) @(negedge clock);
         check(edgeCount, lo, hi);
      end
   endtask
   task t_reset;
      begin
         check({5'h00, mode_r}, 8'h01, 8'h01);
         rd(8'h0c, 8'h02);
         rd(8'h0d, 8'h03);
         rd(8'h0e, 8'h10);
         rd(8'h0f, 8'h00);
         rd(8'h20, 8'h00);
      end
   endtask
   task t_rates;
      begin
         setm(3'h2);
         for (f = 1; f < 4; f = f + 1) begin
            wr(8'h0d, f[7:0]);
            measure(16, 64, (8'h40 >> f) - 8'h01, (8'h40 >> f) + 8'h01);
         end
         wr(8'h0d, 8'h00);
         measure(16, 64, 8'h00, 8'h00);
         setm(3'h3);
         wr(8'h0d, 8'h01);
         measure(16, 64, 8'h1f, 8'h21);
      end
   endtask
   task t_standby;
      begin
         setm(3'h0);
         wr(8'h0d, 8'h03);
         measure(16, 64, 8'h00, 8'h00);
         wr(8'h0c, 8'h03);
         measure(16, 64, 8'h07, 8'h09);
      end
   endtask
   task t_hk;
      begin
         setm(3'h4);
         measure(16, 64, 8'h00, 8'h00);
         wr(8'h0f, 8'h40);
         measure(16, 64, 8'h07, 8'h09);
      end
   endtask
   task t_idle;
      begin
         wr(8'h0e, 8'h04);
         setm(3'h2);
         setm(3'h1);
         measure(0, 60, 8'h03, 8'h05);
         measure(0, 64, 8'h00, 8'h00);
         @(negedge clock);
         packetReceived = 1'b1;
         @(negedge clock);
         packetReceived = 1'b0;
         measure(16, 64, 8'h07, 8'h09);
         wr(8'h10, 8'hff);
         rd(8'h10, 8'h19);
      end
   endtask
   task end_of_test;
      begin
         $display("err_count=%0d comparisons=%0d", err_count, comparisons);
         if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      {resetn, regWrite, regRead, modeReqValid, packetReceived} = 5'h00;
      {regAddr, regWdata, modeReq} = 19'h00000;
      clearCount = 1'b1;
      err_count = 0;
      comparisons = 0;
      repeat (5) @(negedge clock);
      resetn = 1'b1;
      clearCount = 1'b0;
      t_reset;
      t_rates;
      t_standby;
      t_hk;
      t_idle;
      end_of_test;
   end
   // Run needs about 1000 cycles; cut a hang well beyond that
   initial begin
      #100000;
      err_count = err_count + 1;
      end_of_test;
   end
endmodule
